// [common/sync_ctl_defines.svh]
// Offsets, field positions, reset values and timing counts of the sync block
// Assumes pclk at 10 MHz; included by bare name
`ifndef SYNC_CTL_DEFINES_SVH
`define SYNC_CTL_DEFINES_SVH

// Clock
`define CLK_HZ            10000000
`define CLK_NS            100
// Register byte offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_ENERGY        12'h008
`define REG_ROT_COUNT     12'h00C
`define REG_SYNC_PERIOD   12'h010
`define REG_AOUT01        12'h014
`define REG_AOUT23        12'h018
`define REG_DOUT          12'h01C
`define REG_AIN01         12'h020
`define REG_AIN23         12'h024
`define REG_CYCLE_NS      12'h028
`define REG_MEM_PART      12'h02C
`define REG_ERR_CLR       12'h030
// Control fields
`define CTRL_EXT_SYNC     0
`define CTRL_SUMMING      1
`define CTRL_SLAVE        2
`define CTRL_MEM_EXT      3
`define CTRL_SW_START     4
`define CTRL_SW_STOP      5
`define CTRL_RESET        32'h0000_0000
// Timing figures
`define CYC_OUT_PULSE_NS  10000
`define CYC_OUT_CYCLES    ((`CYC_OUT_PULSE_NS / `CLK_NS) > 0 ? \
                           (`CYC_OUT_PULSE_NS / `CLK_NS) : 1)
`define CYC_MIN_MS        50
`define CYC_MIN_CYCLES    ((`CYC_MIN_MS * 1000000 + `CLK_NS - 1) / `CLK_NS)
`define CYC_MAX_S         60
`define CYC_MAX_CYCLES    ((64'd60 * 1000000000) / `CLK_NS)
`define SYNC_MAX_KHZ      500
`define ROT_MAX_KHZ       5000
`define MEM_WORDS_BASE    65536
`define MEM_WORDS_EXT     4194304
`define INT_CYCLE_DEF     32'd10000000

`endif

// [common/sync_ctl_pkg.sv]
// Types of the measurement sync and control block
// Assumes nothing beyond the defines header
package sync_ctl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ACCESS
    } apb_st_t;
    typedef struct packed {
        logic [31:0] ctrl;
        logic        running;
        logic        cyc_err;
        logic        dir_pos;
        logic        both_slave;
        logic [31:0] energy;
        logic [31:0] rot_count;
        logic [31:0] rot_latched;
        logic [31:0] sync_cnt;
        logic [31:0] sync_period;
        logic [31:0] cyc_cnt;
        logic [31:0] int_cycle;
        logic [15:0] pulse_cnt;
        logic [63:0] aout_stage;
        logic [63:0] aout;
        logic [3:0]  dout_stage;
        logic [3:0]  dout;
        logic [63:0] ain_shown;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        sync_out_n;
        logic        ctl_out_n;
        logic        cyc_out_n;
        logic        cyc_tick;
    } state_t;
endpackage

// [hdl/meas_sync_ctl.sv]
// Measurement sync and control logic with an APB register slave
// Assumes one 10 MHz pclk; connector pins and rotation tracks asynchronous
//
// Functional notes
// - Sync pins active low, idle high
// - External mode uses sync-in rising edge
// - Sync-out carries group A frequency
// - Control falling edge clears, starts integration
// - Control rising edge or stop bit write stops integration
// - Control-out high stopped, low running
// - Cycle-in rising edge restarts measurement cycle
// - One about 10 us cycle-out pulse
// - Rate edge samples direction for sign
// - Frequency measured from 0.05 Hz to 500 kHz
// - Four 16-bit analogue outputs refreshed per cycle
// - Four digital outputs updated per cycle
// - Four 16-bit analogue inputs shown per cycle
// - Capture memory split into three parts
// - Rotation input counts up to 5 MHz
// - Slave takes cycle from cycle input
// - Two slaves means measurement halts
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sync_ctl_defines.svh"

module meas_sync_ctl
    import sync_ctl_pkg::*;
#(
    parameter int      AOUT_BITS   = 16,
    parameter longint  CYC_MIN     = `CYC_MIN_CYCLES,
    parameter longint  CYC_MAX     = `CYC_MAX_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Sync connector, active low
    input  wire logic        sync_in_n,
    input  wire logic        ctl_in_n,
    input  wire logic        cyc_in_n,
    output logic             sync_out_n,
    output logic             ctl_out_n,
    output logic             cyc_out_n,
    // Rotation tracks and group A zero crossing
    input  wire logic        rate_track_input,
    input  wire logic        direction_track_input,
    input  wire logic        zero_cross_a,
    // Partner slave setting and process values
    input  wire logic        partner_slave,
    input  wire logic [63:0] ain_sample,
    output logic      [63:0] aout,
    output logic      [3:0]  dout,
    output logic             dir_pos,
    output logic             halted
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (AOUT_BITS != 16) begin : g_bad_width
        $error("Analogue outputs must be 16 bits");
    end
    if (CYC_MIN < 1 || CYC_MAX <= CYC_MIN) begin : g_bad_cyc
        $error("Cycle limits out of order");
    end

    localparam logic [31:0] MIN_C = 32'(CYC_MIN);
    localparam logic [31:0] MAX_C = 32'(CYC_MAX);
    localparam logic [15:0] PULSE = 16'(`CYC_OUT_CYCLES);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] meta_q;   // First stage, read only by second
    logic [4:0] sy_q;     // Second stage
    logic [4:0] dl_q;     // Delayed copy for edges

    // Two flops per asynchronous input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 5'h1F;
            sy_q   <= 5'h1F;
            dl_q   <= 5'h1F;
        end else begin
            meta_q <= {direction_track_input, rate_track_input,
                       cyc_in_n, ctl_in_n, sync_in_n};
            sy_q   <= meta_q;
            dl_q   <= sy_q;
        end
    end

    // Edge decode, low active pins idle high
    function automatic logic rise(input logic now, input logic old);
        return now & ~old;
    endfunction

    logic sync_rise;
    logic ctl_fall;
    logic ctl_rise;
    logic cyc_rise;
    logic rate_rise;
    // Pin level high means the input is inactive
    assign sync_rise = rise(sy_q[0], dl_q[0]);
    assign ctl_fall  = rise(dl_q[1], sy_q[1]);
    assign ctl_rise  = rise(sy_q[1], dl_q[1]);
    assign cyc_rise  = rise(sy_q[2], dl_q[2]);
    assign rate_rise = rise(sy_q[3], dl_q[3]);

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    state_t s_q;   // Whole block state
    state_t s_d;   // Next state

    logic sel_sync;    // Chosen sync event for group A
    logic cyc_end;     // Measurement cycle boundary
    logic wr_acc;      // APB write taken
    logic rd_acc;      // APB read taken
    logic addr_ok;     // Decoded address hit
    logic [31:0] rd_mux;

    // Register read mux
    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            `REG_CTRL:        rd_mux = s_q.ctrl;
            `REG_STATUS:      rd_mux = {27'h0, s_q.both_slave, s_q.dir_pos,
                                        s_q.cyc_err, s_q.running, ctl_out_n};
            `REG_ENERGY:      rd_mux = s_q.energy;
            `REG_ROT_COUNT:   rd_mux = s_q.rot_latched;
            `REG_SYNC_PERIOD: rd_mux = s_q.sync_period;
            `REG_AOUT01:      rd_mux = s_q.aout_stage[31:0];
            `REG_AOUT23:      rd_mux = s_q.aout_stage[63:32];
            `REG_DOUT:        rd_mux = {28'h0, s_q.dout_stage};
            `REG_AIN01:       rd_mux = s_q.ain_shown[31:0];
            `REG_AIN23:       rd_mux = s_q.ain_shown[63:32];
            `REG_CYCLE_NS:    rd_mux = s_q.int_cycle;
            `REG_MEM_PART:    rd_mux = s_q.ctrl[`CTRL_MEM_EXT] ?
                                  32'(`MEM_WORDS_EXT / 3) :
                                  32'(`MEM_WORDS_BASE / 3);
            `REG_ERR_CLR:     rd_mux = 32'h0;
            default: begin
                rd_mux  = 32'h0;
                addr_ok = 1'b0;
            end
        endcase
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.pready   = 1'b0;
        s_d.pslverr  = 1'b0;
        s_d.cyc_tick = 1'b0;
        wr_acc = psel & penable & pwrite & ~s_q.pready;
        rd_acc = psel & penable & ~pwrite & ~s_q.pready;

        // APB: answer one cycle into the access phase
        if (psel && penable && !s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = ~addr_ok;
            s_d.prdata  = rd_acc ? rd_mux : 32'h0;
        end
        if (wr_acc && addr_ok) begin
            case (paddr)
                `REG_CTRL:     s_d.ctrl = pwdata;
                `REG_AOUT01:   s_d.aout_stage[31:0] = pwdata;
                `REG_AOUT23:   s_d.aout_stage[63:32] = pwdata;
                `REG_DOUT:     s_d.dout_stage = pwdata[3:0];
                `REG_CYCLE_NS: s_d.int_cycle = pwdata;
                default:       s_d.ctrl = s_q.ctrl;
            endcase
        end

        // Two meters both set to external cycle halt
        s_d.both_slave = s_q.ctrl[`CTRL_SLAVE] & partner_slave;

        // Sync source: external rising edge or own zero crossing
        sel_sync = s_q.ctrl[`CTRL_EXT_SYNC] ? sync_rise : zero_cross_a;
        if (sel_sync) begin
            s_d.sync_period = s_q.sync_cnt;
            s_d.sync_cnt    = 32'h1;
            s_d.sync_out_n  = 1'b0;
        end else begin
            s_d.sync_cnt = (s_q.sync_cnt == 32'hFFFF_FFFF) ?
                           s_q.sync_cnt : s_q.sync_cnt + 32'h1;
            if (s_q.sync_cnt == {1'b0, s_q.sync_period[31:1]})
                s_d.sync_out_n = 1'b1;      // Half period, back high
        end

        // Energy control: start on falling, stop on rising edge
        if (ctl_fall || (wr_acc && paddr == `REG_CTRL &&
                         pwdata[`CTRL_SW_START])) begin
            if (!s_q.ctrl[`CTRL_SUMMING])
                s_d.energy = 32'h0;
            s_d.running = 1'b1;
        end else if (ctl_rise || (wr_acc && paddr == `REG_CTRL &&
                                  pwdata[`CTRL_SW_STOP])) begin
            s_d.running = 1'b0;
        end else if (s_q.running) begin
            s_d.energy = s_q.energy + 32'h1;
        end
        s_d.ctl_out_n = ~s_d.running;

        // Rotation pulses and direction sign
        if (rate_rise) begin
            s_d.rot_count = s_q.rot_count + 32'h1;
            s_d.dir_pos   = sy_q[4];
        end

        // Cycle timing: slave follows cycle input, master times itself
        s_d.cyc_cnt = (s_q.cyc_cnt == 32'hFFFF_FFFF) ?
                      s_q.cyc_cnt : s_q.cyc_cnt + 32'h1;
        cyc_end = 1'b0;
        if (s_d.both_slave) begin
            cyc_end = 1'b0;
        end else if (s_q.ctrl[`CTRL_SLAVE]) begin
            if (cyc_rise) begin
                if (s_q.cyc_cnt < MIN_C || s_q.cyc_cnt > MAX_C ||
                    s_q.cyc_cnt <= s_q.sync_period) begin
                    s_d.cyc_err = 1'b1;
                end else begin
                    cyc_end = 1'b1;
                end
                s_d.cyc_cnt = 32'h1;
            end
        end else if (s_q.cyc_cnt >= s_q.int_cycle) begin
            cyc_end = 1'b1;
        end
        if (wr_acc && paddr == `REG_ERR_CLR && pwdata[0] && !s_d.cyc_err)
            s_d.cyc_err = 1'b0;
        else if (wr_acc && paddr == `REG_ERR_CLR && pwdata[0] &&
                 !(s_q.ctrl[`CTRL_SLAVE] && cyc_rise && !cyc_end))
            s_d.cyc_err = 1'b0;              // Set wins over clear

        // Cycle boundary effects
        if (cyc_end) begin
            if (!s_q.ctrl[`CTRL_SLAVE])
                s_d.cyc_cnt = 32'h1;
            s_d.cyc_tick    = 1'b1;
            s_d.pulse_cnt   = PULSE;
            s_d.cyc_out_n   = 1'b0;
            s_d.aout        = s_d.aout_stage;
            s_d.dout        = s_d.dout_stage;
            s_d.ain_shown   = ain_sample;
            s_d.rot_latched = s_q.rot_count;
            s_d.rot_count   = 32'h0;
        end else if (s_q.pulse_cnt != 16'h0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - 16'h1;
            if (s_q.pulse_cnt == 16'h1)
                s_d.cyc_out_n = 1'b1;
        end
    end

    // Register the whole state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q            <= '0;
            s_q.ctrl       <= `CTRL_RESET;
            s_q.int_cycle  <= `INT_CYCLE_DEF;
            s_q.dir_pos    <= 1'b1;
            s_q.sync_out_n <= 1'b1;
            s_q.ctl_out_n  <= 1'b1;
            s_q.cyc_out_n  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flops
    // ------------------------------------------------------------
    assign prdata     = s_q.prdata;
    assign pready     = s_q.pready;
    assign pslverr    = s_q.pslverr;
    assign sync_out_n = s_q.sync_out_n;
    assign ctl_out_n  = s_q.ctl_out_n;
    assign cyc_out_n  = s_q.cyc_out_n;
    assign aout       = s_q.aout;
    assign dout       = s_q.dout;
    assign dir_pos    = s_q.dir_pos;
    assign halted     = s_q.both_slave;

endmodule // meas_sync_ctl

`default_nettype wire

// [verification/meas_sync_ctl_props.sv]
// Port checker for the sync and control block
// Assumes one pclk domain; bound onto meas_sync_ctl below
`timescale 1ns/10ps
`default_nettype none
module meas_sync_ctl_props (
    // Clock, reset and APB answer
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Connector pins and process values
    input wire logic        ctl_in_n,
    input wire logic        ctl_out_n,
    input wire logic        cyc_out_n,
    input wire logic        rate_track_input,
    input wire logic        direction_track_input,
    input wire logic        dir_pos,
    input wire logic        partner_slave,
    input wire logic        halted,
    input wire logic [63:0] aout,
    input wire logic [3:0]  dout
);
    // Cycles for which the cycle pulse has stayed low
    logic [7:0] low_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_q <= 8'h00;
        else
            low_q <= cyc_out_n ? 8'h00 : low_q + 8'h01;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Pin changes held long enough to pass the synchroniser
    sequence s_fell; $fell(ctl_in_n) ##0 (!ctl_in_n)[*5]; endsequence
    sequence s_rose; $rose(ctl_in_n) ##0 ctl_in_n[*5]; endsequence
    sequence s_rate;
        $rose(rate_track_input) ##0 $stable(direction_track_input)[*5];
    endsequence
    property p_start; s_fell |=> !ctl_out_n; endproperty
    a_start: assert property (p_start)
        else $error("control out not low after start edge");
    property p_stop; s_rose |=> ctl_out_n; endproperty
    a_stop: assert property (p_stop)
        else $error("control out not high after stop edge");
    property p_pulse; $rose(cyc_out_n) |-> low_q == 8'h64; endproperty
    a_pulse: assert property (p_pulse)
        else $error("cycle pulse not 100 cycles long");
    property p_dir; s_rate |=> dir_pos == direction_track_input; endproperty
    a_dir: assert property (p_dir)
        else $error("direction sign not taken at rate edge");
    property p_upd; $changed(aout) || $changed(dout) |-> $fell(cyc_out_n);
    endproperty
    a_upd: assert property (p_upd)
        else $error("process outputs changed outside cycle start");
    property p_halt; halted |-> $past(partner_slave); endproperty
    a_halt: assert property (p_halt)
        else $error("halted without partner slave");
    property p_rdy; pready |-> $past(psel && penable) ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("ready not a single answer to an access");
    property p_err; pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err: assert property (p_err)
        else $error("error answer malformed");
endmodule // meas_sync_ctl_props
bind meas_sync_ctl meas_sync_ctl_props u_props (.pclk, .presetn, .psel,
    .penable, .pready, .pslverr, .prdata, .ctl_in_n, .ctl_out_n,
    .cyc_out_n, .rate_track_input, .direction_track_input, .dir_pos,
    .partner_slave, .halted, .aout, .dout);
`default_nettype wire

// [verification/sync_partner.sv]
// Model of the linked meter on the sync connector
// Assumes its tasks are called right after a rising pclk edge
`timescale 1ns/10ps
`default_nettype none
module sync_partner (
    // Clock and sync enable
    input  wire logic pclk,
    input  wire logic sync_en,
    // Connector pins toward the block
    output logic      sync_in_n,
    output logic      ctl_in_n,
    output logic      cyc_in_n,
    output logic      partner_slave
);
    int half_q = 0; // Cycles into the sync half period
    // Pins idle high, partner starts as master
    initial begin
        sync_in_n = 1'b1;
        ctl_in_n = 1'b1;
        cyc_in_n = 1'b1;
        partner_slave = 1'b0;
    end
    // Sync frequency, period 60 cycles, idle high when off
    always @(posedge pclk) begin
        half_q <= (half_q == 29) ? 0 : half_q + 1;
        if (!sync_en)
            sync_in_n <= 1'b1;
        else if (half_q == 29)
            sync_in_n <= ~sync_in_n;
    end
    // One cycle period at 50 percent duty, rising edge in the middle
    task cycle(input int half);
        cyc_in_n <= 1'b0;
        repeat (half) @(posedge pclk);
        cyc_in_n <= 1'b1;
        repeat (half) @(posedge pclk);
    endtask
    // Energy control level
    task ctl(input logic lvl);
        ctl_in_n <= lvl;
    endtask
    // Partner cycle time set to zero
    task slave(input logic v);
        partner_slave <= v;
    endtask
endmodule // sync_partner
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench of the sync and control block
// Assumes the checker is bound and the partner drives the connector
`timescale 1ns/10ps
`default_nettype none
`include "sync_ctl_defines.svh"
module tb_top;
    logic        pclk, presetn, psel, penable;
    logic        pwrite, pready, pslverr, sync_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, a0, a1, dv;
    logic        sync_in_n, ctl_in_n, cyc_in_n, sync_out_n, ctl_out_n;
    logic        cyc_out_n, rate_track_input, zero_cross_a = 1'b0;
    logic        direction_track_input, partner_slave, dir_pos;
    logic        halted, d, was_q = 1'b1;
    logic [63:0] ain_sample, aout;
    logic [3:0]  dout;
    logic [64:0] apb_q[$], note; // Error, mask, data per transfer
    logic [67:0] cyc_q[$], seen; // Dout and aout per cycle pulse
    int          n_errors = 0, n_compared = 0, cycles = 0, zc_q = 0, k, i;
    int unsigned seed;
    meas_sync_ctl #(.CYC_MIN(50), .CYC_MAX(5000)) dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sync_in_n, .ctl_in_n, .cyc_in_n, .sync_out_n,
        .ctl_out_n, .cyc_out_n, .rate_track_input, .direction_track_input,
        .zero_cross_a, .partner_slave, .ain_sample, .aout, .dout, .dir_pos,
        .halted);
    sync_partner p (.pclk, .sync_en, .sync_in_n, .ctl_in_n, .cyc_in_n,
        .partner_slave);
    // Clock, internal zero crossing every 40 cycles, hang limit
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        zc_q <= (zc_q == 39) ? 0 : zc_q + 1;
        zero_cross_a <= (zc_q == 39);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            stop_test;
        end
    end
    task chk(input string nm, input logic [63:0] got, input logic [63:0] e);
        n_compared++;
        if (got !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, got);
        end
    endtask
    // APB transfer held until ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dat,
             input logic [64:0] n);
        apb_q.push_back(n);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat, 65'h0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, m, e});
    endtask
    // Rotation pulses with a fixed direction level
    task rot(input int n, input logic dl);
        direction_track_input <= dl;
        repeat (4) @(posedge pclk);
        repeat (n) begin
            rate_track_input <= 1'b1;
            repeat (2) @(posedge pclk);
            rate_track_input <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
    // Monitor: answers and cycle pulses against the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            note = apb_q.pop_front();
            chk("pslverr", pslverr, note[64]);
            chk("prdata", prdata & note[63:32], note[31:0]);
        end
        if (cyc_out_n === 1'b0 && was_q === 1'b1) begin
            seen = cyc_q.pop_front();
            chk("aout", aout, seen[63:0]);
            chk("dout", dout, seen[67:64]);
        end
        was_q <= cyc_out_n;
    end
    // Main sequence
    initial begin
        seed = $urandom(99252);
        // Inputs start idle while reset is held
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        sync_en <= 1'b0;
        rate_track_input <= 1'b0;
        direction_track_input <= 1'b0;
        ain_sample <= 64'h0;
        repeat (12) @(posedge pclk);
        chk("idle", {sync_out_n, ctl_out_n, cyc_out_n, dir_pos}, 4'hF);
        presetn <= 1'b1;
        wr(`REG_CTRL, 32'h0000_0004);
        rd(`REG_STATUS, 32'h0000_001F, 32'h0000_0009);
        apb(1'b0, 12'h040, 32'h0, {1'b1, 32'hFFFF_FFFF, 32'h0});
        for (i = 0; i < 3; i++) begin
            a0 = $urandom;
            a1 = $urandom;
            dv = $urandom;
            d = 1'($urandom);
            k = $urandom_range(1, 9);
            wr(`REG_AOUT01, a0);
            wr(`REG_AOUT23, a1);
            wr(`REG_DOUT, dv);
            ain_sample <= {$urandom, $urandom};
            rot(k, d);
            cyc_q.push_back({dv[3:0], a1, a0});
            p.cycle(100);
            repeat (8) @(posedge pclk);
            chk("dir_pos", dir_pos, d);
            rd(`REG_ROT_COUNT, 32'hFFFF_FFFF, k);
            rd(`REG_AIN01, 32'hFFFF_FFFF, ain_sample[31:0]);
        end
        cyc_q.push_back({dv[3:0], a1, a0});
        p.cycle(10);
        p.cycle(10);
        repeat (8) @(posedge pclk);
        rd(`REG_STATUS, 32'h0000_0004, 32'h0000_0004);
        wr(`REG_ERR_CLR, 32'h0000_0001);
        rd(`REG_STATUS, 32'h0000_0004, 32'h0);
        p.ctl(1'b0);
        repeat (8) @(posedge pclk);
        chk("ctl_out_n", ctl_out_n, 1'b0);
        rd(`REG_STATUS, 32'h0000_0002, 32'h0000_0002);
        p.ctl(1'b1);
        repeat (8) @(posedge pclk);
        chk("ctl_out_n", ctl_out_n, 1'b1);
        p.slave(1'b1);
        repeat (3) @(posedge pclk);
        chk("halted", halted, 1'b1);
        p.slave(1'b0);
        repeat (3) @(posedge pclk);
        chk("halted", halted, 1'b0);
        rd(`REG_SYNC_PERIOD, 32'hFFFF_FFFF, 32'h0000_0028);
        wr(`REG_CTRL, 32'h0000_0005);
        sync_en <= 1'b1;
        repeat (200) @(posedge pclk);
        rd(`REG_SYNC_PERIOD, 32'hFFFF_FFFF, 32'h0000_003C);
        repeat (10) @(posedge pclk);
        chk("notes left", apb_q.size() + cyc_q.size(), 64'h0);
        stop_test;
    end
    task stop_test;
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
endmodule // tb_top
`default_nettype wire
